// file: sample_mux_sequencer.sv
// Multiplexer sequencer: frames, conversion start, sample store, chopper swap and frame sync
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module sample_mux_sequencer (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        slow_sample_clock,
  input  wire logic        main_power_good,
  input  wire logic        accum_period_last,
  input  wire logic [21:0] adc_result,
  output logic      [2:0]  mux_select,
  output logic             conversion_start,
  output logic             resolution_select,
  output logic             battery_sense_enable,
  output logic             chopper_swap,
  output logic             frame_sync,
  output logic             ce_pass_start,
  output logic             live_monitor_readout_start,
  output logic             sample_write,
  output logic      [6:0]  sample_addr,
  output logic      [31:0] sample_data
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic sample_mux_sequencer_pkg::mux_sel_type pick_input(input logic alt, input logic [1:0] idx);
    sample_mux_sequencer_pkg::mux_sel_type sel;
    sel = sample_mux_sequencer_pkg::SEL_PHASE_A_CURRENT;
    case (idx)
      2'h0: sel = alt ? sample_mux_sequencer_pkg::SEL_THERMAL : sample_mux_sequencer_pkg::SEL_PHASE_A_CURRENT;
      2'h1: sel = sample_mux_sequencer_pkg::SEL_PHASE_A_VOLTAGE;
      2'h2: sel = alt ? sample_mux_sequencer_pkg::SEL_BATTERY : sample_mux_sequencer_pkg::SEL_PHASE_B_CURRENT;
      2'h3: sel = sample_mux_sequencer_pkg::SEL_PHASE_B_VOLTAGE;
      default: sel = sample_mux_sequencer_pkg::SEL_PHASE_A_CURRENT;
    endcase
    return sel;
  endfunction : pick_input

  function automatic logic [6:0] slot_of(input sample_mux_sequencer_pkg::mux_sel_type sel);
    logic [6:0] slot;
    slot = sample_mux_sequencer_pkg::SLOT_IA;
    case (sel)
      sample_mux_sequencer_pkg::SEL_PHASE_A_CURRENT: slot = sample_mux_sequencer_pkg::SLOT_IA;
      sample_mux_sequencer_pkg::SEL_PHASE_A_VOLTAGE: slot = sample_mux_sequencer_pkg::SLOT_VA;
      sample_mux_sequencer_pkg::SEL_PHASE_B_CURRENT: slot = sample_mux_sequencer_pkg::SLOT_IB;
      sample_mux_sequencer_pkg::SEL_PHASE_B_VOLTAGE: slot = sample_mux_sequencer_pkg::SLOT_VB;
      sample_mux_sequencer_pkg::SEL_THERMAL:         slot = sample_mux_sequencer_pkg::SLOT_THERMAL;
      sample_mux_sequencer_pkg::SEL_BATTERY:         slot = sample_mux_sequencer_pkg::SLOT_BATTERY;
      default:                                        slot = sample_mux_sequencer_pkg::SLOT_IA;
    endcase
    return slot;
  endfunction : slot_of

  // Reserved counts are pinned to the legal range rather than running wild
  function automatic logic [2:0] clamp_states(input logic [2:0] spf);
    logic [2:0] n;
    n = spf;
    if (spf > sample_mux_sequencer_pkg::SPF_MAX) begin
      n = sample_mux_sequencer_pkg::SPF_MAX;
    end else if (spf < sample_mux_sequencer_pkg::SPF_MIN) begin
      n = sample_mux_sequencer_pkg::SPF_MIN;
    end
    return n;
  endfunction : clamp_states

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [1:0]  chop_mode_r;
  logic [2:0]  states_per_frame_r;
  logic        alternate_frame_request_r;
  logic        resolution_select_r;
  logic [1:0]  meter_formula_select_r;
  logic        battery_sense_enable_r;
  logic        batt_eff;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      chop_mode_r               <= sample_mux_sequencer_pkg::CHOP_MODE_RESET;
      states_per_frame_r        <= sample_mux_sequencer_pkg::SPF_RESET;
      alternate_frame_request_r <= 1'b0;
      resolution_select_r       <= sample_mux_sequencer_pkg::RES_SEL_RESET;
      meter_formula_select_r    <= sample_mux_sequencer_pkg::FORMULA_RESET;
      battery_sense_enable_r    <= 1'b0;
    end else if (reg_write) begin
      case (reg_addr)
        sample_mux_sequencer_pkg::ADDR_CHOP_CTRL: begin
          chop_mode_r <= reg_wdata[sample_mux_sequencer_pkg::CHOP_MODE_LSB +: 2];
        end
        sample_mux_sequencer_pkg::ADDR_MUX_CTRL: begin
          states_per_frame_r        <= reg_wdata[sample_mux_sequencer_pkg::SPF_LSB +: 3];
          alternate_frame_request_r <= reg_wdata[sample_mux_sequencer_pkg::ALT_REQ_BIT];
          resolution_select_r       <= reg_wdata[sample_mux_sequencer_pkg::RES_SEL_BIT];
          meter_formula_select_r    <= reg_wdata[sample_mux_sequencer_pkg::FORMULA_LSB +: 2];
        end
        sample_mux_sequencer_pkg::ADDR_BATT_CTRL: begin
          battery_sense_enable_r <= reg_wdata[sample_mux_sequencer_pkg::BATT_EN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Stored bit is kept, but loses effect without main power
  assign batt_eff = battery_sense_enable_r & main_power_good;

  // ****************************************
  // Alternate request capture
  // ****************************************
  logic alt_req_prev_r;
  logic alt_pending_r;
  logic frame_begin;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      alt_req_prev_r <= 1'b0;
    end else begin
      alt_req_prev_r <= alternate_frame_request_r;
    end
  end

  // Edge seen per fast cycle, so even a one-cycle pulse is caught; set wins over clear
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      alt_pending_r <= 1'b0;
    end else if (alternate_frame_request_r && !alt_req_prev_r) begin
      alt_pending_r <= 1'b1;
    end else if (frame_begin) begin
      alt_pending_r <= 1'b0;
    end
  end

  // ****************************************
  // Slow clock edge
  // ****************************************
  logic slow_prev_r;
  logic slow_rise;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      slow_prev_r <= 1'b0;
    end else begin
      slow_prev_r <= slow_sample_clock;
    end
  end

  assign slow_rise = slow_sample_clock & ~slow_prev_r;

  // ****************************************
  // Frame sequencer
  // ****************************************
  sample_mux_sequencer_pkg::seq_state_type seq_r;
  logic [1:0]  state_idx_r;
  logic [1:0]  cyc_cnt_r;
  logic [1:0]  conv_len_r;
  logic [2:0]  frame_states_r;
  logic        alt_frame_r;
  logic        conv_last;
  logic        frame_last;

  assign frame_begin = slow_rise && (seq_r != sample_mux_sequencer_pkg::SEQ_CONVERT);
  assign conv_last   = (cyc_cnt_r == conv_len_r - 2'h1);
  assign frame_last  = ({1'b0, state_idx_r} == frame_states_r - 3'h1);

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      seq_r          <= sample_mux_sequencer_pkg::SEQ_WAIT;
      state_idx_r    <= 2'h0;
      cyc_cnt_r      <= 2'h0;
      conv_len_r     <= sample_mux_sequencer_pkg::CONV_CYC_LONG;
      frame_states_r <= sample_mux_sequencer_pkg::SPF_RESET;
      alt_frame_r    <= 1'b0;
    end else if (slow_rise) begin
      case (seq_r)
        sample_mux_sequencer_pkg::SEQ_WAIT,
        sample_mux_sequencer_pkg::SEQ_SETTLE: begin
          // Settings are frozen for a whole frame
          seq_r          <= sample_mux_sequencer_pkg::SEQ_CONVERT;
          state_idx_r    <= 2'h0;
          cyc_cnt_r      <= 2'h0;
          frame_states_r <= clamp_states(states_per_frame_r);
          conv_len_r     <= resolution_select_r ? sample_mux_sequencer_pkg::CONV_CYC_LONG
                                                : sample_mux_sequencer_pkg::CONV_CYC_SHORT;
          alt_frame_r    <= alt_pending_r;
        end
        sample_mux_sequencer_pkg::SEQ_CONVERT: begin
          if (!conv_last) begin
            cyc_cnt_r <= cyc_cnt_r + 2'h1;
          end else if (frame_last) begin
            seq_r     <= sample_mux_sequencer_pkg::SEQ_SETTLE;
            cyc_cnt_r <= 2'h0;
          end else begin
            state_idx_r <= state_idx_r + 2'h1;
            cyc_cnt_r   <= 2'h0;
          end
        end
        default: begin
          seq_r <= sample_mux_sequencer_pkg::SEQ_WAIT;
        end
      endcase
    end
  end

  // ****************************************
  // Multiplexer select and conversion start
  // ****************************************
  logic [2:0] mux_select_r;
  logic       conversion_start_r;
  logic       resolution_out_r;
  logic       conv_start_nxt;
  logic [1:0] next_idx;
  logic       next_alt;

  assign conv_start_nxt = slow_rise && (frame_begin || (seq_r == sample_mux_sequencer_pkg::SEQ_CONVERT
                                                        && conv_last && !frame_last));
  assign next_idx = frame_begin ? 2'h0 : state_idx_r + 2'h1;
  assign next_alt = frame_begin ? alt_pending_r : alt_frame_r;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mux_select_r       <= sample_mux_sequencer_pkg::SEL_PHASE_A_CURRENT;
      conversion_start_r <= 1'b0;
      resolution_out_r   <= sample_mux_sequencer_pkg::RES_SEL_RESET;
    end else begin
      conversion_start_r <= conv_start_nxt;
      if (conv_start_nxt) begin
        mux_select_r <= pick_input(next_alt, next_idx);
        if (frame_begin) begin
          resolution_out_r <= resolution_select_r;
        end
      end
    end
  end

  // ****************************************
  // Sample memory write
  // ****************************************
  logic        sample_write_r;
  logic [6:0]  sample_addr_r;
  logic [31:0] sample_data_r;
  logic [21:0] result_masked;

  // Short filter yields one bit less; top bit is forced off
  assign result_masked = conv_len_r == sample_mux_sequencer_pkg::CONV_CYC_LONG ? adc_result
                                                                              : {1'b0, adc_result[20:0]};

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sample_write_r <= 1'b0;
      sample_addr_r  <= sample_mux_sequencer_pkg::SLOT_IA;
      sample_data_r  <= 32'h00000000;
    end else begin
      sample_write_r <= slow_rise && (seq_r == sample_mux_sequencer_pkg::SEQ_CONVERT) && conv_last;
      if (slow_rise && (seq_r == sample_mux_sequencer_pkg::SEQ_CONVERT) && conv_last) begin
        sample_addr_r <= slot_of(sample_mux_sequencer_pkg::mux_sel_type'(mux_select_r));
        sample_data_r <= {1'b0, result_masked, 9'h000};
      end
    end
  end

  // ****************************************
  // Chopper swap and frame sync
  // ****************************************
  logic chopper_swap_r;
  logic frame_sync_r;
  logic ce_pass_start_r;
  logic enter_settle;

  assign enter_settle = slow_rise && (seq_r == sample_mux_sequencer_pkg::SEQ_CONVERT) && conv_last && frame_last;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      chopper_swap_r <= 1'b0;
    end else if (enter_settle) begin
      case (chop_mode_r)
        sample_mux_sequencer_pkg::CHOP_POSITIVE: chopper_swap_r <= 1'b0;
        sample_mux_sequencer_pkg::CHOP_REVERSE:  chopper_swap_r <= 1'b1;
        default: begin
          // Skipping one toggle keeps the pattern aligned to each accumulation period
          if (!accum_period_last) begin
            chopper_swap_r <= ~chopper_swap_r;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      frame_sync_r    <= 1'b0;
      ce_pass_start_r <= 1'b0;
    end else begin
      ce_pass_start_r <= enter_settle;
      if (enter_settle) begin
        frame_sync_r <= 1'b1;
      end else if (frame_begin) begin
        frame_sync_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] reg_rdata_r;
  logic       batt_out_r;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      batt_out_r <= 1'b0;
    end else begin
      batt_out_r <= batt_eff;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        sample_mux_sequencer_pkg::ADDR_CHOP_CTRL: reg_rdata_r <= {2'h0, chop_mode_r, 4'h0};
        sample_mux_sequencer_pkg::ADDR_MUX_CTRL: begin
          reg_rdata_r <= {meter_formula_select_r, resolution_select_r, alternate_frame_request_r,
                          1'b0, states_per_frame_r};
        end
        sample_mux_sequencer_pkg::ADDR_BATT_CTRL: reg_rdata_r <= {1'b0, battery_sense_enable_r, 6'h00};
        sample_mux_sequencer_pkg::ADDR_MUX_STATUS: begin
          reg_rdata_r <= {1'b0, batt_eff, frame_sync_r, chopper_swap_r, alt_pending_r, alt_frame_r, state_idx_r};
        end
        default: reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  assign reg_rdata                  = reg_rdata_r;
  assign mux_select                 = mux_select_r;
  assign conversion_start           = conversion_start_r;
  assign resolution_select          = resolution_out_r;
  assign battery_sense_enable       = batt_out_r;
  assign chopper_swap               = chopper_swap_r;
  assign frame_sync                 = frame_sync_r;
  assign ce_pass_start              = ce_pass_start_r;
  assign live_monitor_readout_start = ce_pass_start_r;
  assign sample_write               = sample_write_r;
  assign sample_addr                = sample_addr_r;
  assign sample_data                = sample_data_r;

endmodule : sample_mux_sequencer

// file: sample_mux_sequencer_assertions.sv
// Port-level assertions for the sample multiplexer sequencer
`timescale 1ns/1ps
module sample_mux_sequencer_assertions (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        main_power_good,
  input wire logic [2:0]  mux_select,
  input wire logic        conversion_start,
  input wire logic        battery_sense_enable,
  input wire logic        chopper_swap,
  input wire logic        frame_sync,
  input wire logic        ce_pass_start,
  input wire logic        live_monitor_readout_start,
  input wire logic        sample_write,
  input wire logic [6:0]  sample_addr,
  input wire logic [31:0] sample_data
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_batt_off;
    !main_power_good |=> !battery_sense_enable;
  endproperty
  a_batt_off: assert property (p_batt_off) else $error("battery path on without power");
  property p_conv_pulse;
    conversion_start |=> !conversion_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("start pulse too long");
  property p_sync_len;
    $rose(frame_sync) |-> frame_sync[*8];
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("frame sync too short");
  property p_pass;
    (ce_pass_start || live_monitor_readout_start) |-> ce_pass_start && live_monitor_readout_start && frame_sync;
  endproperty
  a_pass: assert property (p_pass) else $error("pass start outside frame sync");
  property p_settle;
    frame_sync && $past(frame_sync) |-> !sample_write;
  endproperty
  a_settle: assert property (p_settle) else $error("sample stored in settling cycle");
  property p_swap;
    $changed(chopper_swap) |-> $rose(frame_sync);
  endproperty
  a_swap: assert property (p_swap) else $error("swap changed off frame end");
  property p_mux;
    $changed(mux_select) |-> conversion_start;
  endproperty
  a_mux: assert property (p_mux) else $error("select changed without start");
  property p_addr;
    sample_write |-> sample_addr inside {7'h00, 7'h01, 7'h02, 7'h03, 7'h06, 7'h07} && sample_data[8:0] == 9'h000;
  endproperty
  a_addr: assert property (p_addr) else $error("bad sample word or alignment");
endmodule : sample_mux_sequencer_assertions
bind sample_mux_sequencer sample_mux_sequencer_assertions chk (.mclk(mclk), .rst_n(rst_n),
  .main_power_good(main_power_good), .mux_select(mux_select), .conversion_start(conversion_start),
  .battery_sense_enable(battery_sense_enable), .chopper_swap(chopper_swap), .frame_sync(frame_sync),
  .ce_pass_start(ce_pass_start), .live_monitor_readout_start(live_monitor_readout_start),
  .sample_write(sample_write), .sample_addr(sample_addr), .sample_data(sample_data));

// file: sample_mux_sequencer_bench.sv
// Self-checking bench for the sample multiplexer sequencer
`timescale 1ns/1ps
module sample_mux_sequencer_bench;
  // ****************************************
  // Signals and model state
  // ****************************************
  localparam int P = 20;
  logic        mclk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, main_power_good = 1'b1;
  logic        accum_period_last = 1'b0, slow_sample_clock, conversion_start, resolution_select;
  logic        battery_sense_enable, chopper_swap, frame_sync, ce_pass_start, live_monitor_readout_start;
  logic        sample_write, alt_pend = 1'b0, alt_run = 1'b0, alt_last = 1'b0, res_cfg = 1'b1, res_cur;
  logic        swap_exp = 1'b0, sync_q = 1'b0, batt_cfg = 1'b0, mem_q = 1'b0;
  logic [1:0]  mode_cfg = 2'h0;
  logic [2:0]  mux_select;
  logic [6:0]  sample_addr;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rdv, wv;
  logic [15:0] reg_addr = 16'h0000;
  logic [21:0] adc_result;
  logic [31:0] sample_data, seed = 32'h7965, d_q;
  int          fails = 0, samples_checked = 0, idx = 0, w = 0, gap = 0, n_cfg = 4, n_cur = 4, frames = 0, cyc = 0, f;
  int          a_q = 0;
  int          reg_mux[4] = '{0, 1, 2, 3}, alt_mux[4] = '{4, 1, 5, 3}, alt_slot[4] = '{6, 1, 7, 3};

  initial forever #2.5 mclk = ~mclk;

  sample_mux_sequencer uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .slow_sample_clock(slow_sample_clock),
    .main_power_good(main_power_good), .accum_period_last(accum_period_last), .adc_result(adc_result),
    .mux_select(mux_select), .conversion_start(conversion_start), .resolution_select(resolution_select),
    .battery_sense_enable(battery_sense_enable), .chopper_swap(chopper_swap), .frame_sync(frame_sync),
    .ce_pass_start(ce_pass_start), .live_monitor_readout_start(live_monitor_readout_start),
    .sample_write(sample_write), .sample_addr(sample_addr), .sample_data(sample_data));
  sample_mux_sequencer_partner #(.HALF(P / 2)) far (.mclk(mclk), .sample_write(sample_write),
    .sample_addr(sample_addr), .sample_data(sample_data), .slow_sample_clock(slow_sample_clock),
    .adc_result(adc_result));

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    if (a == sample_mux_sequencer_pkg::ADDR_MUX_CTRL) begin
      n_cfg = d[2:0] < 2 ? 2 : d[2:0] > 4 ? 4 : d[2:0];
      res_cfg = d[5];
      if (d[4] && !alt_last) alt_pend = 1'b1;
      alt_last = d[4];
    end
    if (a == sample_mux_sequencer_pkg::ADDR_CHOP_CTRL) mode_cfg = d[5:4];
    if (a == sample_mux_sequencer_pkg::ADDR_BATT_CTRL) batt_cfg = d[6];
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : rd
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // ****************************************
  // Model compare, values seen before each edge
  // ****************************************
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end else if (rst_n) begin
      gap++;
      // Word written one edge ago must now sit in the far-side memory
      if (mem_q) check(far.mem[a_q], d_q);
      mem_q = 1'b0;
      if (conversion_start) begin
        if (idx == 0) begin
          alt_run = alt_pend;
          alt_pend = 1'b0;
          n_cur = n_cfg;
          res_cur = res_cfg;
          frames++;
        end else check(gap, res_cur ? 3 * P : 2 * P);
        check(mux_select, alt_run ? alt_mux[idx] : reg_mux[idx]);
        check(resolution_select, res_cur);
        idx++;
        gap = 0;
      end
      if (sample_write) begin
        a_q = alt_run ? alt_slot[w] : reg_mux[w];
        d_q = {1'b0, res_cur & adc_result[21], adc_result[20:0], 9'h000};
        mem_q = 1'b1;
        check(sample_addr, a_q);
        check(sample_data, d_q);
        w++;
      end
      if (frame_sync && !sync_q) begin
        check(w, n_cur);
        if (mode_cfg < 2) swap_exp = mode_cfg[0];
        else if (!accum_period_last) swap_exp = ~swap_exp;
        check(chopper_swap, swap_exp);
        check({ce_pass_start, live_monitor_readout_start}, 2'h3);
        check(battery_sense_enable, batt_cfg & main_power_good);
        idx = 0;
        w = 0;
      end
      sync_q = frame_sync;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(sample_mux_sequencer_pkg::ADDR_MUX_CTRL, rdv);
    check(rdv, 8'h24);
    rd(16'h1234, rdv);
    check(rdv, 8'h00);
    wr(sample_mux_sequencer_pkg::ADDR_CHOP_CTRL, 8'h30);
    rd(sample_mux_sequencer_pkg::ADDR_CHOP_CTRL, rdv);
    check(rdv[5:4], 2'h3);
    // Settings go in just after a frame starts, far from its end
    for (int k = 0; k < 24; k++) begin
      f = frames;
      wait (frames != f);
      rd(sample_mux_sequencer_pkg::ADDR_MUX_STATUS, rdv);
      check(rdv, {1'b0, batt_cfg & main_power_good, 1'b0, swap_exp, 1'b0, alt_run, 2'h0});
      seed = xs(seed);
      // Counts above four are reserved, so software never writes them
      wv = (seed[2:0] > 3'h4) ? {seed[7:3], 3'h4} : seed[7:0];
      for (int j = 0; j <= int'(seed[8]); j++) begin
        wr(sample_mux_sequencer_pkg::ADDR_MUX_CTRL, wv);
        wr(sample_mux_sequencer_pkg::ADDR_MUX_CTRL, wv & 8'hEF);
      end
      wr(sample_mux_sequencer_pkg::ADDR_CHOP_CTRL, {2'h0, seed[10:9], 4'h0});
      wr(sample_mux_sequencer_pkg::ADDR_BATT_CTRL, {1'b0, seed[11], 6'h00});
      main_power_good <= seed[12];
      accum_period_last <= seed[13];
    end
    test_done;
  end
endmodule : sample_mux_sequencer_bench

// file: sample_mux_sequencer_partner.sv
// Far side model: slow clock, converter result and sample memory
`timescale 1ns/1ps
module sample_mux_sequencer_partner #(
  parameter int HALF = 10
) (
  input  wire logic        mclk,
  input  wire logic        sample_write,
  input  wire logic [6:0]  sample_addr,
  input  wire logic [31:0] sample_data,
  output logic             slow_sample_clock,
  output logic      [21:0] adc_result
);
  // ****************************************
  // Slow clock and result source
  // ****************************************
  // Slow clock sped up to keep runs short
  logic [31:0] mem [0:127];
  int          cnt = 0;
  initial slow_sample_clock = 1'b0;
  initial adc_result = 22'h2A5C3;
  always @(posedge mclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      slow_sample_clock <= ~slow_sample_clock;
      // New result after a falling edge only, so it is stable at each rise
      if (slow_sample_clock) adc_result <= {adc_result[20:0], adc_result[21] ^ adc_result[16]};
    end
    if (sample_write) mem[sample_addr] <= sample_data;
  end
endmodule : sample_mux_sequencer_partner

// file: sample_mux_sequencer_pkg.sv
// Constants, encodings and register map of the sample multiplexer sequencer
package sample_mux_sequencer_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] ADDR_CHOP_CTRL  = 16'h2002;
  localparam logic [15:0] ADDR_MUX_CTRL   = 16'h2003;
  localparam logic [15:0] ADDR_MUX_STATUS = 16'h2004;
  localparam logic [15:0] ADDR_BATT_CTRL  = 16'h2020;

  // Chopper control fields
  localparam int          CHOP_MODE_LSB   = 4;
  localparam logic [1:0]  CHOP_MODE_RESET = 2'h0;

  // Multiplexer control fields
  localparam int          SPF_LSB         = 0;
  localparam int          ALT_REQ_BIT     = 4;
  localparam int          RES_SEL_BIT     = 5;
  localparam int          FORMULA_LSB     = 6;
  localparam logic [2:0]  SPF_RESET       = 3'h4;
  localparam logic [2:0]  SPF_MIN         = 3'h2;
  localparam logic [2:0]  SPF_MAX         = 3'h4;
  localparam logic        RES_SEL_RESET   = 1'h1;
  localparam logic [1:0]  FORMULA_RESET   = 2'h0;

  // Battery control field
  localparam int          BATT_EN_BIT     = 6;

  // Status fields
  localparam int          STAT_IDX_LSB    = 0;
  localparam int          STAT_ALT_BIT    = 2;
  localparam int          STAT_PEND_BIT   = 3;
  localparam int          STAT_SWAP_BIT   = 4;
  localparam int          STAT_SYNC_BIT   = 5;
  localparam int          STAT_BATT_BIT   = 6;

  // ****************************************
  // Conversion and sample memory
  // ****************************************
  localparam logic [1:0]  CONV_CYC_SHORT  = 2'h2;
  localparam logic [1:0]  CONV_CYC_LONG   = 2'h3;
  localparam int          RESULT_BITS     = 22;
  localparam int          SAMPLE_SHIFT    = 9;

  localparam logic [6:0]  SLOT_IA         = 7'h00;
  localparam logic [6:0]  SLOT_VA         = 7'h01;
  localparam logic [6:0]  SLOT_IB         = 7'h02;
  localparam logic [6:0]  SLOT_VB         = 7'h03;
  localparam logic [6:0]  SLOT_THERMAL    = 7'h06;
  localparam logic [6:0]  SLOT_BATTERY    = 7'h07;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SEL_PHASE_A_CURRENT = 3'h0,
    SEL_PHASE_A_VOLTAGE = 3'h1,
    SEL_PHASE_B_CURRENT = 3'h2,
    SEL_PHASE_B_VOLTAGE = 3'h3,
    SEL_THERMAL         = 3'h4,
    SEL_BATTERY         = 3'h5
  } mux_sel_type;

  typedef enum logic [1:0] {
    CHOP_POSITIVE = 2'h0,
    CHOP_REVERSE  = 2'h1,
    CHOP_TOGGLE   = 2'h2,
    CHOP_TOGGLE_B = 2'h3
  } chop_mode_type;

  typedef enum logic [1:0] {
    SEQ_WAIT    = 2'h0,
    SEQ_CONVERT = 2'h1,
    SEQ_SETTLE  = 2'h2
  } seq_state_type;

endpackage : sample_mux_sequencer_pkg
